// >>> verilog/adcseq_top.sv
// Converter sequencing core and serial port
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adcseq_top
    import adcseq_pkg::*;
#(
    parameter int CONV_CYC = `ADCSEQ_CONV_CYC,
    parameter int PWRUP_CYC = `ADCSEQ_PWRUP_CYC,
    parameter int CNT_W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic conv_start_n,
    input wire logic [`ADCSEQ_RES_BITS-1:0] conv_code,
    input wire logic sclk,
    input wire logic read_frame_sync,
    input wire logic write_frame_sync,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic pwr_sel_hi,
    output logic pwr_sel_lo,
    output logic powered,
    output logic hold,
    output logic conv_busy
);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYC - 1);

    function automatic logic is_auto(input logic [1:0] sel);
        is_auto = (sel != `ADCSEQ_PWR_FULL_UP) &&
                  (sel != `ADCSEQ_PWR_FULL_DOWN);
    endfunction : is_auto

    // Core clock domain
    logic cs_s1_ff, cs_s2_ff, cs_d_ff;
    logic pt_s1_ff, pt_s2_ff, pt_d_ff;
    logic [1:0] pwr_ff;
    adcseq_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic fall_pend_ff, nxt_fall_pend;
    logic [`ADCSEQ_RES_BITS-1:0] res_ff;
    logic res_tgl_ff;
    logic powered_ff, hold_ff, busy_ff;
    logic cs_fall, cs_rise, conv_end, pwrup_end;

    // Link clock domain
    logic srst_s1_ff, srst_n_ff;
    logic rfs_d_ff, tfs_d_ff;
    logic rt_s1_ff, rt_s2_ff, rt_d_ff;
    logic pend_ff;
    logic [`ADCSEQ_RES_BITS-1:0] hold_ff_l;
    logic [`ADCSEQ_RES_BITS-1:0] tx_sh_ff;
    logic [3:0] rd_cnt_ff;
    logic rd_act_ff, dout_ff, dout_oe_ff;
    logic [3:0] wr_cnt_ff;
    logic wr_act_ff, wr_tgl_ff;
    logic [1:0] pwr_wr_ff;
    logic pwr_tgl_ff;
    logic wr_seen_ff;
    logic [`ADCSEQ_WR_BITS-1:0] din_sh_ff;
    logic [3:0] din_cnt_ff;
    logic rd_go, wr_go, res_new, hold_load;

    // Start pin synchroniser and edge detect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_d_ff <= 1'b1;
        end else begin
            cs_s1_ff <= conv_start_n;
            cs_s2_ff <= cs_s1_ff;
            cs_d_ff <= cs_s2_ff;
        end
    end

    assign cs_fall = cs_d_ff & ~cs_s2_ff;
    assign cs_rise = ~cs_d_ff & cs_s2_ff;
    assign conv_end = (state_ff == ADCSEQ_CONV) && (cnt_ff == CONV_LAST);
    assign pwrup_end = (state_ff == ADCSEQ_PWRUP) &&
                       (cnt_ff == PWRUP_LAST);

    // Power select word taken from the link side by toggle handshake
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pt_s1_ff <= 1'b0;
            pt_s2_ff <= 1'b0;
            pt_d_ff <= 1'b0;
            pwr_ff <= `ADCSEQ_PWR_RST;
        end else begin
            pt_s1_ff <= pwr_tgl_ff;
            pt_s2_ff <= pt_s1_ff;
            pt_d_ff <= pt_s2_ff;
            if (pt_s2_ff != pt_d_ff) begin
                pwr_ff <= pwr_wr_ff;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_fall_pend = fall_pend_ff;
        case (state_ff)
            ADCSEQ_DOWN: begin
                nxt_cnt = '0;
                nxt_fall_pend = 1'b0;
                if (pwr_ff == `ADCSEQ_PWR_FULL_UP) begin
                    nxt_state = ADCSEQ_PWRUP;
                end else if (is_auto(pwr_ff) && cs_rise) begin
                    nxt_state = ADCSEQ_PWRUP;
                end
            end
            ADCSEQ_PWRUP: begin
                if (cs_fall) begin
                    nxt_fall_pend = 1'b1;
                end
                if (pwr_ff == `ADCSEQ_PWR_FULL_DOWN) begin
                    nxt_state = ADCSEQ_DOWN;
                end else if (pwrup_end) begin
                    nxt_cnt = '0;
                    nxt_fall_pend = 1'b0;
                    if (fall_pend_ff || cs_fall) begin
                        nxt_state = ADCSEQ_CONV;
                    end else begin
                        nxt_state = ADCSEQ_TRACK;
                    end
                end
            end
            ADCSEQ_TRACK: begin
                nxt_cnt = '0;
                if (cs_fall) begin
                    nxt_state = ADCSEQ_CONV;
                end else if (pwr_ff == `ADCSEQ_PWR_FULL_DOWN) begin
                    nxt_state = ADCSEQ_DOWN;
                end
            end
            ADCSEQ_CONV: begin
                if (conv_end) begin
                    nxt_cnt = '0;
                    if (pwr_ff == `ADCSEQ_PWR_FULL_UP) begin
                        nxt_state = ADCSEQ_TRACK;
                    end else if (pwr_ff == `ADCSEQ_PWR_FULL_DOWN) begin
                        nxt_state = ADCSEQ_DOWN;
                    end else if (cs_s2_ff) begin
                        nxt_state = ADCSEQ_TRACK;
                    end else begin
                        nxt_state = ADCSEQ_DOWN;
                    end
                end
            end
            default: begin
                nxt_state = ADCSEQ_DOWN;
                nxt_cnt = '0;
                nxt_fall_pend = 1'b0;
            end
        endcase
    end

    // Sequencer state and interval counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= ADCSEQ_DOWN;
            cnt_ff <= '0;
            fall_pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fall_pend_ff <= nxt_fall_pend;
        end
    end

    // Status outputs registered from next state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            powered_ff <= 1'b0;
            hold_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            powered_ff <= (nxt_state != ADCSEQ_DOWN);
            hold_ff <= (nxt_state == ADCSEQ_CONV);
            busy_ff <= (nxt_state == ADCSEQ_CONV);
        end
    end

    // Result capture at conversion end, announced by toggle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_ff <= '0;
            res_tgl_ff <= 1'b0;
        end else if (conv_end) begin
            res_ff <= conv_code;
            res_tgl_ff <= ~res_tgl_ff;
        end
    end

    assign powered = powered_ff;
    assign hold = hold_ff;
    assign conv_busy = busy_ff;
    assign pwr_sel_hi = pwr_ff[1];
    assign pwr_sel_lo = pwr_ff[0];

    // Link side reset synchroniser
    always_ff @(posedge sclk) begin
        srst_s1_ff <= rst_n;
        srst_n_ff <= srst_s1_ff;
    end

    // Frame sync edge detect; link pins are link-clock signals
    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            rfs_d_ff <= 1'b0;
            tfs_d_ff <= 1'b1;
        end else begin
            rfs_d_ff <= read_frame_sync;
            tfs_d_ff <= write_frame_sync;
        end
    end

    assign rd_go = read_frame_sync & ~rfs_d_ff;
    assign wr_go = tfs_d_ff & ~write_frame_sync;

    // New result arrival and deferred load
    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            rt_s1_ff <= 1'b0;
            rt_s2_ff <= 1'b0;
            rt_d_ff <= 1'b0;
        end else begin
            rt_s1_ff <= res_tgl_ff;
            rt_s2_ff <= rt_s1_ff;
            rt_d_ff <= rt_s2_ff;
        end
    end

    assign res_new = rt_s2_ff ^ rt_d_ff;
    assign hold_load = pend_ff & ~rd_act_ff & ~rd_go;

    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= res_new | (pend_ff & ~hold_load);
        end
    end

    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            hold_ff_l <= '0;
        end else if (hold_load) begin
            hold_ff_l <= res_ff;
        end
    end

    // Read shifter: MSB first on rising edges
    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            tx_sh_ff <= '0;
            rd_cnt_ff <= '0;
            rd_act_ff <= 1'b0;
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
        end else if (rd_go) begin
            dout_ff <= hold_ff_l[`ADCSEQ_RES_BITS-1];
            tx_sh_ff <= {hold_ff_l[`ADCSEQ_RES_BITS-2:0], 1'b0};
            dout_oe_ff <= 1'b1;
            rd_cnt_ff <= 4'h1;
            rd_act_ff <= 1'b1;
        end else if (rd_act_ff) begin
            if (rd_cnt_ff == `ADCSEQ_RD_LAST) begin
                dout_oe_ff <= 1'b0;
                dout_ff <= 1'b0;
                rd_act_ff <= 1'b0;
                rd_cnt_ff <= `ADCSEQ_RD_DONE;
            end else begin
                dout_ff <= tx_sh_ff[`ADCSEQ_RES_BITS-1];
                tx_sh_ff <= {tx_sh_ff[`ADCSEQ_RES_BITS-2:0], 1'b0};
                rd_cnt_ff <= rd_cnt_ff + 4'h1;
            end
        end
    end

    assign dout = dout_ff;
    assign dout_oe = dout_oe_ff;

    // Write frame: rising edge count, update on the 13th
    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            wr_cnt_ff <= '0;
            wr_act_ff <= 1'b0;
            wr_tgl_ff <= 1'b0;
            pwr_wr_ff <= `ADCSEQ_PWR_RST;
            pwr_tgl_ff <= 1'b0;
        end else if (wr_go) begin
            wr_cnt_ff <= 4'h1;
            wr_act_ff <= 1'b1;
            wr_tgl_ff <= ~wr_tgl_ff;
        end else if (wr_act_ff) begin
            wr_cnt_ff <= wr_cnt_ff + 4'h1;
            if (wr_cnt_ff == `ADCSEQ_WR_LAST) begin
                wr_act_ff <= 1'b0;
                pwr_wr_ff <= {din_sh_ff[`ADCSEQ_PWR_HI_BIT],
                              din_sh_ff[`ADCSEQ_PWR_LO_BIT]};
                pwr_tgl_ff <= ~pwr_tgl_ff;
            end
        end
    end

    // Data in captured on falling edges after the frame starts
    always_ff @(negedge sclk) begin
        if (!srst_n_ff) begin
            wr_seen_ff <= 1'b0;
            din_sh_ff <= '0;
            din_cnt_ff <= '0;
        end else if (wr_tgl_ff != wr_seen_ff) begin
            wr_seen_ff <= wr_tgl_ff;
            din_sh_ff <= {din_sh_ff[`ADCSEQ_WR_BITS-2:0], din};
            din_cnt_ff <= 4'h1;
        end else if (din_cnt_ff != 4'h0 &&
                     din_cnt_ff < 4'(`ADCSEQ_WR_BITS)) begin
            din_sh_ff <= {din_sh_ff[`ADCSEQ_WR_BITS-2:0], din};
            din_cnt_ff <= din_cnt_ff + 4'h1;
        end
    end

    // Helper counters for interval checks
    logic [CNT_W-1:0] busy_len_ff, pwr_len_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_len_ff <= '0;
            pwr_len_ff <= '0;
        end else begin
            busy_len_ff <= busy_ff ? busy_len_ff + CNT_W'(1) : '0;
            pwr_len_ff <= (state_ff == ADCSEQ_PWRUP) ?
                          pwr_len_ff + CNT_W'(1) : '0;
        end
    end

    function automatic logic [3:0] sat_inc(input logic [3:0] n);
        sat_inc = (n == 4'h0 || n == 4'hf) ? n : n + 4'h1;
    endfunction : sat_inc

    // Link edges counted since the last frame start
    logic [3:0] rd_edge_ff, wr_edge_ff;
    always_ff @(posedge sclk) begin
        if (!srst_n_ff) begin
            rd_edge_ff <= '0;
            wr_edge_ff <= '0;
        end else begin
            rd_edge_ff <= rd_go ? 4'h1 : sat_inc(rd_edge_ff);
            wr_edge_ff <= wr_go ? 4'h1 : sat_inc(wr_edge_ff);
        end
    end

    conv_length_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(busy_ff) |-> busy_len_ff == CNT_W'(CONV_CYC))
        else $error("conversion length wrong");

    pwrup_length_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($past(state_ff) == ADCSEQ_PWRUP && state_ff != ADCSEQ_PWRUP &&
         state_ff != ADCSEQ_DOWN) |-> pwr_len_ff == CNT_W'(PWRUP_CYC))
        else $error("power-up length wrong");

    result_load_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(busy_ff) |-> res_tgl_ff != $past(res_tgl_ff))
        else $error("result not captured at conversion end");

    auto_down_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (conv_end && is_auto(pwr_ff) && !cs_s2_ff) |=> !powered_ff)
        else $error("auto mode did not power down");

    stay_up_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (conv_end && cs_s2_ff && pwr_ff != `ADCSEQ_PWR_FULL_DOWN) |=>
        powered_ff ##1 powered_ff)
        else $error("powered down with start pin high");

    start_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ADCSEQ_TRACK && cs_fall) |=> hold_ff && busy_ff)
        else $error("falling start edge did not hold");

    short_pulse_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (pwrup_end && fall_pend_ff) |=> busy_ff)
        else $error("pending start lost after power-up");

    dout_float_a: assert property (
        @(posedge sclk) disable iff (!srst_n_ff)
        (rd_edge_ff == 4'ha && !rd_go) |-> dout_oe_ff ##1 !dout_oe_ff)
        else $error("data out did not float on 11th edge");

    dout_drive_a: assert property (
        @(posedge sclk) disable iff (!srst_n_ff)
        rd_go |=> dout_oe_ff)
        else $error("data out not driven after read sync");

    ctrl_update_a: assert property (
        @(posedge sclk) disable iff (!srst_n_ff)
        (wr_edge_ff == 4'hc && !wr_go) |=> pwr_tgl_ff != $past(pwr_tgl_ff))
        else $error("control not updated on 13th edge");

    hold_defer_a: assert property (
        @(posedge sclk) disable iff (!srst_n_ff)
        rd_act_ff |=> $stable(hold_ff_l))
        else $error("result loaded during a read");

endmodule : adcseq_top

// >>> shared/adcseq_cfg.svh
// Constants for the converter mode sequencer
// What this block does
// - Start pin high at end: stay powered, except with power select 00
// - Start pin low at end: power down, except with power select 11
// - Start falling edge holds sample, starts conversion
// - Conversion lasts 2.3 us, result to shifter
// - Read enabled on first shift edge after sync
// - Early read shifts out previous result
// - New result waits until running read ends
// - Read after 2.3 us gives new result
// - Read accepted any time after start rise
// - Powered down in auto mode: rising start begins 1.5 us power-up
// - Short start pulse: finish power-up, then convert
// - Auto mode, start pin low at end: load result, power down immediately
// - Serial port works while core powered down
// - Five serial wires: clock, two syncs, data
// - Power select: 11 up, 00 down, else auto
// - Data out on rising edges, float on 11th
// - Data in on falling edges, update on 13th
// - Sync edge resets counter; extra edges ignored
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH

`define ADCSEQ_MCLK_NS 100
`define ADCSEQ_CONV_NS 2300
`define ADCSEQ_PWRUP_NS 1500
`define ADCSEQ_CONV_CYC \
    ((`ADCSEQ_CONV_NS + `ADCSEQ_MCLK_NS - 1) / `ADCSEQ_MCLK_NS)
`define ADCSEQ_PWRUP_CYC \
    ((`ADCSEQ_PWRUP_NS + `ADCSEQ_MCLK_NS - 1) / `ADCSEQ_MCLK_NS)
`define ADCSEQ_RES_BITS 10
`define ADCSEQ_RD_LAST 4'ha
`define ADCSEQ_RD_DONE 4'hb
`define ADCSEQ_WR_BITS 12
`define ADCSEQ_WR_LAST 4'hc
`define ADCSEQ_PWR_HI_BIT 11
`define ADCSEQ_PWR_LO_BIT 10
`define ADCSEQ_PWR_RST 2'h0
`define ADCSEQ_PWR_FULL_UP 2'h3
`define ADCSEQ_PWR_FULL_DOWN 2'h0

`endif

// >>> shared/adcseq_pkg.sv
// Types for the converter mode sequencer
package adcseq_pkg;
    typedef enum logic [1:0] {
        ADCSEQ_DOWN,
        ADCSEQ_PWRUP,
        ADCSEQ_TRACK,
        ADCSEQ_CONV
    } adcseq_state_t;
endpackage : adcseq_pkg

// >>> tb/adcseq_host.sv
// Host serial port model for the five-wire link
`timescale 1ns/1ps
module adcseq_host (
    output logic sclk,
    output logic read_frame_sync,
    output logic write_frame_sync,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    initial begin
        sclk = 1'b0;
        read_frame_sync = 1'b0;
        write_frame_sync = 1'b1;
        din = 1'b0;
    end

    // Link clock pulses, still between frames
    task automatic tick(input int n);
        repeat (n) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
    endtask : tick

    // Lead-in, sync rise, 11 edges, then one edge to be ignored
    task automatic rd(output logic [9:0] data, output logic [11:0] oe);
        tick(4);
        read_frame_sync = 1'b1;
        for (int i = 11; i >= 0; i--) begin
            if (i == 0) begin
                read_frame_sync = 1'b0;
            end
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
            oe[i] = dout_oe;
            if (i >= 2) begin
                data[i-2] = dout;
            end
        end
        #100;
    endtask : rd

    // 12 bits MSB first, latched on edge 13
    task automatic wr(input logic [11:0] word);
        write_frame_sync = 1'b0;
        for (int i = 12; i >= 0; i--) begin
            #40 sclk = 1'b1;
            if (i > 0) begin
                din = word[i-1];
            end
            #40 sclk = 1'b0;
        end
        write_frame_sync = 1'b1;
        tick(1);
    endtask : wr
endmodule : adcseq_host

// >>> tb/adc_conversion_mode_sequencer_test.sv
// Self-checking bench for the converter mode sequencer
`timescale 1ns/1ps
module adc_conversion_mode_sequencer_test import adcseq_pkg::*;;
    localparam int CONV = 23;
    localparam int PWUP = 15;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic conv_start_n = 1'b1;
    logic [9:0] conv_code = 10'h000;
    wire sclk, read_frame_sync, write_frame_sync, din;
    logic dout, dout_oe, pwr_sel_hi, pwr_sel_lo, powered, hold, conv_busy;
    // Released data line shows the inverse of dout, which is cleared to 0
    wire dout_line;
    assign dout_line = dout_oe ? dout : ~dout;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [9:0] d;
    logic [11:0] oe;
    int n, m;

    adcseq_top #(.CONV_CYC(CONV), .PWRUP_CYC(PWUP)) uut (
        .mclk(mclk), .rst_n(rst_n), .conv_start_n(conv_start_n),
        .conv_code(conv_code), .sclk(sclk),
        .read_frame_sync(read_frame_sync),
        .write_frame_sync(write_frame_sync), .din(din), .dout(dout),
        .dout_oe(dout_oe), .pwr_sel_hi(pwr_sel_hi),
        .pwr_sel_lo(pwr_sel_lo), .powered(powered), .hold(hold),
        .conv_busy(conv_busy)
    );
    adcseq_host host (
        .sclk(sclk), .read_frame_sync(read_frame_sync),
        .write_frame_sync(write_frame_sync), .din(din),
        .dout(dout_line), .dout_oe(dout_oe)
    );

    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc

    task automatic pin(input logic v);
        @(posedge mclk);
        conv_start_n <= v;
    endtask : pin

    // Cycles until hold rises, bounded
    task automatic wait_hold(output int k);
        k = 0;
        while (hold !== 1'b1 && k < 60) begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask : wait_hold

    // Busy length, start pin driven to lvl meanwhile
    task automatic busy_len(input logic lvl, output int k);
        k = 0;
        while (conv_busy === 1'b1 && k < 60) begin
            @(posedge mclk);
            conv_start_n <= lvl;
            #1;
            k++;
        end
    endtask : busy_len

    // Conversion from tracking: fall, measure, end level lvl
    task automatic convert(input logic [9:0] code, input logic lvl);
        conv_code <= code;
        pin(1'b0);
        wait_hold(n);
        check(16'(n >= 3 && n <= 5), 16'h1);
        busy_len(lvl, m);
        check(16'(m), 16'(CONV));
        cyc(3);
        check(16'(powered), 16'(lvl));
    endtask : convert

    task automatic t_reset();
        check({powered, hold, conv_busy, pwr_sel_hi, pwr_sel_lo, dout_oe},
            16'h0);
        host.wr(12'hc00);
        cyc(10);
        check({pwr_sel_hi, pwr_sel_lo, powered}, 16'h7);
        host.wr(12'h800);
        cyc(10);
        check({pwr_sel_hi, pwr_sel_lo, powered}, 16'h5);
        $display("reset and power select done");
    endtask : t_reset

    task automatic t_modes();
        convert(10'h2a5, 1'b1);
        host.rd(d, oe);
        check(d, 16'h2a5);
        check(oe, 16'hffc);
        convert(10'h15a, 1'b0);
        host.rd(d, oe);
        check(d, 16'h15a);
        $display("mode one and two done");
    endtask : t_modes

    task automatic t_pwrup();
        conv_code <= 10'h0c3;
        pin(1'b1);
        cyc(2);
        pin(1'b0);
        wait_hold(n);
        check(16'(n + 3 >= PWUP && n <= PWUP + 4), 16'h1);
        busy_len(1'b0, m);
        check(16'(m), 16'(CONV));
        cyc(3);
        check(16'(powered), 16'h0);
        host.rd(d, oe);
        check(d, 16'h0c3);
        pin(1'b1);
        cyc(PWUP + 5);
        check(16'(powered), 16'h1);
        convert(10'h0f0, 1'b1);
        $display("power-up done");
    endtask : t_pwrup

    task automatic t_overlap();
        fork
            begin
                cyc(18);
                host.rd(d, oe);
            end
            convert(10'h333, 1'b1);
        join
        check(d, 16'h0f0);
        cyc(4);
        host.rd(d, oe);
        check(d, 16'h333);
        $display("read overlap done");
    endtask : t_overlap

    task automatic t_off();
        host.wr(12'h000);
        cyc(10);
        check({pwr_sel_hi, pwr_sel_lo, powered}, 16'h0);
        pin(1'b0);
        cyc(30);
        check(16'(hold), 16'h0);
        pin(1'b1);
        host.wr(12'h400);
        cyc(10);
        check({pwr_sel_hi, pwr_sel_lo, powered}, 16'h2);
        $display("power off done");
    endtask : t_off

    initial begin
        fork
            host.tick(5);
            cyc(4);
        join
        @(posedge mclk);
        rst_n <= 1'b1;
        host.tick(3);
        cyc(3);
        t_reset();
        t_modes();
        t_pwrup();
        t_overlap();
        t_off();
        stop_test();
    end
endmodule : adc_conversion_mode_sequencer_test
